// File: core/vtar_regs.sv
// VLAN table access registers, table storage and forwarding lookup.
`timescale 1ns/100ps
`include "vtar_defines.svh"
module vtar_regs
  import vtar_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Register port.
  input  wire logic [`VT_ADDR_W-1:0] addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata_q,
  // Forwarding lookup request from the switch fabric.
  input  wire logic                 lu_req,
  input  wire logic [11:0]          lu_vid,
  input  wire logic [6:0]           lu_port_map,
  output logic                      lu_ack_q,
  output vtar_lu_s                  lu_res_q,
  // Key for the address lookup hash.
  output vtar_key_s                 key_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state.

  vtar_entry_s  table_mem [4096];   // The VLAN table itself.
  vtar_entry_s  stage_q;            // Staged entry seen by software.
  logic [11:0]  index_q;            // Entry selected for an action.
  logic         start_q;            // Action start and busy flag.
  vtar_act_e    act_q;              // Action to perform.
  vtar_state_e  state_q;            // Sequencer state.
  logic [11:0]  sweep_q;            // Clear-all position.
  logic         done;               // Action finishes this cycle.
  logic         go;                 // Pending action accepted now.

  // Address hit test, shared by the write and read decoders.
  function automatic logic hit(input logic [`VT_ADDR_W-1:0] a,
                               input logic [`VT_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Packs the first entry word so that read-back and checks agree.
  function automatic logic [31:0] attr_word(input vtar_entry_s e);
    logic [31:0] w;
    w = 32'h00000000;
    w[`VT_VALID_BIT] = e.valid;
    w[`VT_OVR_BIT] = e.ovr;
    w[`VT_PRIO_HI:`VT_PRIO_LO] = e.prio;
    w[`VT_INST_HI:`VT_INST_LO] = e.inst;
    w[`VT_GID_HI:`VT_GID_LO] = e.filter_group_id;
    attr_word = w;
  endfunction : attr_word

  assign go = start_q && (state_q == VTAR_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Single-cycle actions end at once; the clear-all sweep ends on the last
  // entry. The sweep blocks a second action until every entry is zero.
  always_comb begin
    done = 1'b0;
    if (go) begin
      done = (act_q != VTAR_ACT_CLR);
    end else if (state_q == VTAR_SWEEP) begin
      done = (sweep_q == `VT_CLR_LAST);
    end
  end

  // State and sweep position.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= VTAR_IDLE;
      sweep_q <= 12'h000;
    end else begin
      unique case (state_q)
        VTAR_IDLE: begin
          if (go && act_q == VTAR_ACT_CLR) begin
            state_q <= VTAR_SWEEP;
            sweep_q <= 12'h000;
          end
        end
        VTAR_SWEEP: begin
          // Stepping stops on the last entry so the count never wraps.
          if (sweep_q == `VT_CLR_LAST) begin
            state_q <= VTAR_IDLE;
          end else begin
            sweep_q <= sweep_q + 12'h001;
          end
        end
      endcase
    end
  end

  // Table writes: the sweep zeroes entries, a write action stores staging.
  always_ff @(posedge clk_sys) begin
    if (state_q == VTAR_SWEEP) begin
      table_mem[sweep_q] <= '0;
    end else if (go && act_q == VTAR_ACT_WR) begin
      table_mem[index_q] <= stage_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and index registers.

  // Start bit: software sets it; completion clears it. A software write of
  // the control byte is taken as given, since software must poll first.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      start_q <= 1'b0;
      act_q   <= VTAR_ACT_NOP;
    end else if (wr && hit(addr, `VT_OFF_CTRL)) begin
      start_q <= wdata[`VT_START_BIT];
      act_q   <= vtar_act_e'(wdata[`VT_ACT_HI:0]);
    end else if (done) begin
      start_q <= 1'b0;
    end
  end

  // Entry index register.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      index_q <= `VT_RST_INDEX;
    end else if (wr && hit(addr, `VT_OFF_INDEX)) begin
      index_q <= wdata[`VT_INDEX_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staged entry.

  // A read action overwrites staging in its cycle and wins over a software
  // write, because the hardware result is what software waits for.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage_q <= '0;
    end else if (go && act_q == VTAR_ACT_RD) begin
      stage_q <= table_mem[index_q];
    end else if (wr && hit(addr, `VT_OFF_ATTR)) begin
      stage_q.valid <= wdata[`VT_VALID_BIT];
      stage_q.ovr   <= wdata[`VT_OVR_BIT];
      stage_q.prio  <= wdata[`VT_PRIO_HI:`VT_PRIO_LO];
      stage_q.inst  <= wdata[`VT_INST_HI:`VT_INST_LO];
      stage_q.filter_group_id <= wdata[`VT_GID_HI:`VT_GID_LO];
    end else if (wr && hit(addr, `VT_OFF_STRIP)) begin
      stage_q.strip <= wdata[`VT_MASK_HI:0];
    end else if (wr && hit(addr, `VT_OFF_EGRESS)) begin
      stage_q.egress <= wdata[`VT_MASK_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address lookup key.

  // Group id, station address and direct-mode selector for the hash.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      key_q.direct        <= 1'b0;
      key_q.group         <= `VT_RST_GRP;
      key_q.station[47:32] <= `VT_RST_STA_HI;
      key_q.station[31:0] <= `VT_RST_STA_LO;
    end else if (wr && hit(addr, `VT_OFF_LU_UPPER)) begin
      key_q.group         <= wdata[`VT_GRP_HI:`VT_GRP_LO];
      key_q.station[47:32] <= wdata[`VT_STA_HI:0];
    end else if (wr && hit(addr, `VT_OFF_LU_LOWER)) begin
      key_q.station[31:0] <= wdata;
    end else if (wr && hit(addr, `VT_OFF_LU_CTRL)) begin
      key_q.direct        <= wdata[`VT_DIRECT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back.

  // Read data stand for exactly one cycle; unmapped addresses return zero.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else if (!rd) begin
      rdata_q <= 32'h00000000;
    end else if (hit(addr, `VT_OFF_ATTR)) begin
      rdata_q <= attr_word(stage_q);
    end else if (hit(addr, `VT_OFF_STRIP)) begin
      rdata_q <= {25'h0000000, stage_q.strip};
    end else if (hit(addr, `VT_OFF_EGRESS)) begin
      rdata_q <= {25'h0000000, stage_q.egress};
    end else if (hit(addr, `VT_OFF_INDEX)) begin
      rdata_q <= {20'h00000, index_q};
    end else if (hit(addr, `VT_OFF_CTRL)) begin
      rdata_q <= {24'h000000, start_q, 5'h00, act_q};
    end else if (hit(addr, `VT_OFF_LU_UPPER)) begin
      rdata_q <= {9'h000, key_q.group, key_q.station[47:32]};
    end else if (hit(addr, `VT_OFF_LU_LOWER)) begin
      rdata_q <= key_q.station[31:0];
    end else if (hit(addr, `VT_OFF_LU_CTRL)) begin
      rdata_q <= {29'h00000000, key_q.direct, 2'h0};
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding lookup.

  // An invalid entry never overrides; frames then follow the lookup map.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lu_ack_q <= 1'b0;
      lu_res_q <= '0;
    end else begin
      lu_ack_q <= lu_req;
      if (lu_req) begin
        lu_res_q.valid <= table_mem[lu_vid].valid;
        lu_res_q.strip <= table_mem[lu_vid].strip;
        lu_res_q.prio  <= table_mem[lu_vid].prio;
        lu_res_q.inst  <= table_mem[lu_vid].inst;
        lu_res_q.filter_group_id <= table_mem[lu_vid].filter_group_id;
        if (table_mem[lu_vid].valid && table_mem[lu_vid].ovr) begin
          lu_res_q.fwd <= table_mem[lu_vid].egress;
        end else begin
          lu_res_q.fwd <= lu_port_map;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_start_self_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    wr && hit(addr, `VT_OFF_CTRL) && wdata[`VT_START_BIT] &&
    wdata[`VT_ACT_HI:0] != 2'h3 && state_q == VTAR_IDLE
    ##1 !wr |=> !start_q;
  endproperty
  a_start_self_clear: assert property (p_start_self_clear)
    else $error("start bit did not clear after a short action");

  property p_sweep_end;
    @(posedge clk_sys) disable iff (!rst_b)
    state_q == VTAR_SWEEP && sweep_q == `VT_CLR_LAST && !wr
    |=> state_q == VTAR_IDLE && !start_q;
  endproperty
  a_sweep_end: assert property (p_sweep_end)
    else $error("clear-all did not finish on the last entry");

  property p_read_loads;
    @(posedge clk_sys) disable iff (!rst_b)
    go && act_q == VTAR_ACT_RD |=> stage_q == $past(table_mem[index_q]);
  endproperty
  a_read_loads: assert property (p_read_loads)
    else $error("read action did not load the staged entry");

  property p_override_fwd;
    @(posedge clk_sys) disable iff (!rst_b)
    lu_req ##1 (lu_ack_q && lu_res_q.valid &&
                $past(table_mem[lu_vid].ovr))
    |-> lu_res_q.fwd == $past(table_mem[lu_vid].egress);
  endproperty
  a_override_fwd: assert property (p_override_fwd)
    else $error("override entry did not use the egress mask");

  property p_default_fwd;
    @(posedge clk_sys) disable iff (!rst_b)
    lu_req && !(table_mem[lu_vid].valid && table_mem[lu_vid].ovr)
    |=> lu_ack_q && lu_res_q.fwd == $past(lu_port_map);
  endproperty
  a_default_fwd: assert property (p_default_fwd)
    else $error("non-override entry did not follow the lookup map");

  property p_attr_readback;
    @(posedge clk_sys) disable iff (!rst_b)
    rd && hit(addr, `VT_OFF_ATTR)
    |=> rdata_q[`VT_PRIO_HI:`VT_PRIO_LO] == $past(stage_q.prio) &&
        rdata_q[`VT_INST_HI:`VT_INST_LO] == $past(stage_q.inst) &&
        rdata_q[`VT_GID_HI:0] == $past(stage_q.filter_group_id) &&
        rdata_q[`VT_VALID_BIT] == $past(stage_q.valid);
  endproperty
  a_attr_readback: assert property (p_attr_readback)
    else $error("attribute word read-back mismatch");

  property p_mask_upper_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    rd && (hit(addr, `VT_OFF_STRIP) || hit(addr, `VT_OFF_EGRESS))
    |=> rdata_q[31:7] == 25'h0000000;
  endproperty
  a_mask_upper_zero: assert property (p_mask_upper_zero)
    else $error("reserved mask bits read nonzero");

  property p_upper_key;
    @(posedge clk_sys) disable iff (!rst_b)
    wr && hit(addr, `VT_OFF_LU_UPPER) ##1 !wr ##1
    rd && hit(addr, `VT_OFF_LU_UPPER)
    |=> rdata_q[22:0] == $past(wdata[22:0], 3);
  endproperty
  a_upper_key: assert property (p_upper_key)
    else $error("upper lookup index did not hold the written key");

  property p_read_one_cycle;
    @(posedge clk_sys) disable iff (!rst_b)
    !rd |=> rdata_q == 32'h00000000;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data stood beyond its cycle");

endmodule : vtar_regs

// File: core/vtar_defines.svh
// Offsets, field positions, reset values and counts of the VLAN table bank.
// Overview of operation
// - Attribute bit 31 marks entry valid.
// - Override bit 27 forwards to egress mask only.
// - Override clear forwards by lookup port map.
// - Priority held in attribute bits 26:24.
// - Spanning instance held in bits 14:12.
// - Filter group id held in bits 6:0.
// - Strip mask bits 6:0 untag ports 7:1.
// - Egress mask bits 6:0, used under override.
// - Twelve-bit index selects the table entry.
// - Start bit 7 self-clears when action completes.
// - Action: none, write, read, clear all.
// - Upper lookup index holds group bits 22:16.
// - Upper lookup index holds address bits 15:0.
// - Lower address word; direct mode uses 11:0.
`ifndef VTAR_DEFINES_SVH
`define VTAR_DEFINES_SVH
// Register addresses.
`define VT_ADDR_W        12
`define VT_OFF_ATTR      12'h400
`define VT_OFF_STRIP     12'h404
`define VT_OFF_EGRESS    12'h408
`define VT_OFF_INDEX     12'h40C
`define VT_OFF_CTRL      12'h40E
`define VT_OFF_LU_UPPER  12'h410
`define VT_OFF_LU_LOWER  12'h414
`define VT_OFF_LU_CTRL   12'h418
// Field positions.
`define VT_VALID_BIT     31
`define VT_OVR_BIT       27
`define VT_PRIO_HI       26
`define VT_PRIO_LO       24
`define VT_INST_HI       14
`define VT_INST_LO       12
`define VT_GID_HI        6
`define VT_GID_LO        0
`define VT_MASK_HI       6
`define VT_INDEX_HI      11
`define VT_START_BIT     7
`define VT_ACT_HI        1
`define VT_GRP_HI        22
`define VT_GRP_LO        16
`define VT_STA_HI        15
`define VT_DIRECT_BIT    2
`define VT_DIRIDX_HI     11
// Reset values.
`define VT_RST_INDEX     12'h000
`define VT_RST_ACT       2'h0
`define VT_RST_GRP       7'h00
`define VT_RST_STA_HI    16'h0000
`define VT_RST_STA_LO    32'h00000000
// Timing count: last entry swept by the clear-all action.
`define VT_CLR_LAST      12'hFFF
`endif

// File: core/vtar_pkg.sv
// Types shared by the VLAN table access bank.
package vtar_pkg;
  // One VLAN table entry as stored and staged.
  typedef struct packed {
    logic       valid;
    logic       ovr;
    logic [2:0] prio;
    logic [2:0] inst;
    logic [6:0] filter_group_id;
    logic [6:0] strip;
    logic [6:0] egress;
  } vtar_entry_s;
  // Table action codes.
  typedef enum logic [1:0] {
    VTAR_ACT_NOP = 2'h0,
    VTAR_ACT_WR  = 2'h1,
    VTAR_ACT_RD  = 2'h2,
    VTAR_ACT_CLR = 2'h3
  } vtar_act_e;
  // Sequencer states.
  typedef enum logic [0:0] {
    VTAR_IDLE,
    VTAR_SWEEP
  } vtar_state_e;
  // Result of a forwarding lookup.
  typedef struct packed {
    logic       valid;
    logic [6:0] fwd;
    logic [6:0] strip;
    logic [2:0] prio;
    logic [2:0] inst;
    logic [6:0] filter_group_id;
  } vtar_lu_s;
  // Hash key handed to the address lookup.
  typedef struct packed {
    logic        direct;
    logic [6:0]  group;
    logic [47:0] station;
  } vtar_key_s;
endpackage : vtar_pkg

// File: tb/tb.sv
// Self-checking bench for the VLAN table access register bank.
`timescale 1ns/100ps
`include "vtar_defines.svh"
module tb
  import vtar_pkg::*;
;
  // Clock, reset and register port.
  logic                  clk_sys = 1'b0;
  logic                  rst_b = 1'b0;
  logic [`VT_ADDR_W-1:0] addr = '0;
  logic [31:0]           wdata = '0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [31:0]           rdata_q;
  // Lookup side.
  logic                  lu_req = 1'b0;
  logic [11:0]           lu_vid = '0;
  logic [6:0]            lu_port_map = '0;
  logic                  lu_ack_q;
  vtar_lu_s              lu_res_q;
  vtar_key_s             key_q;
  // Scoreboard: bit 32 of a read note says whether to compare it.
  logic [32:0]           rd_notes[$];
  vtar_lu_s              lu_notes[$];
  logic                  rd_d = 1'b0;
  logic [31:0]           last_rd = '0;
  int                    mismatches = 0;
  int                    check_count = 0;

  vtar_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .lu_req(lu_req),
    .lu_vid(lu_vid), .lu_port_map(lu_port_map), .lu_ack_q(lu_ack_q),
    .lu_res_q(lu_res_q), .key_q(key_q));

  // The clock toggles every 2 ns, for a period of 4 ns.
  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Shared compare, verdict and bus tasks.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, input logic c,
                        input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    rd_notes.push_back({c, e});
    @(posedge clk_sys);
    rd   <= 1'b0;
  endtask : rd_reg

  // Polls until the start bit drops; a sweep takes about 4098 cycles.
  task automatic run_action(input logic [1:0] act);
    wr_reg(`VT_OFF_CTRL, {24'h0, 1'b1, 5'h1F, act});
    for (int i = 0; i < 2000; i++) begin
      rd_reg(`VT_OFF_CTRL, 1'b0, 32'h0);
      repeat (2) @(posedge clk_sys);
      if (last_rd[7] === 1'b0) break;
    end
    check(last_rd[7], 1'b0);
    rd_reg(`VT_OFF_CTRL, 1'b1, {30'h0, act});
  endtask : run_action

  task automatic lookup(input logic [11:0] v, input logic [6:0] m,
                        input vtar_lu_s e);
    @(posedge clk_sys);
    lu_req     <= 1'b1;
    lu_vid     <= v;
    lu_port_map <= m;
    lu_notes.push_back(e);
    @(posedge clk_sys);
    lu_req     <= 1'b0;
  endtask : lookup

  // Expected lookup answer; an invalid entry never overrides the map.
  function automatic vtar_lu_s exp_lu(input vtar_entry_s e,
                                      input logic [6:0] m);
    vtar_lu_s r;
    r.valid = e.valid;
    r.fwd   = (e.valid && e.ovr) ? e.egress : m;
    r.strip = e.strip;
    r.prio  = e.prio;
    r.inst  = e.inst;
    r.filter_group_id = e.filter_group_id;
    return r;
  endfunction : exp_lu

  function automatic logic [31:0] attr_w(input vtar_entry_s e);
    return {e.valid, 3'h0, e.ovr, e.prio, 9'h0, e.inst, 5'h0,
            e.filter_group_id};
  endfunction : attr_w

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever a result shows.
  always @(posedge clk_sys) begin
    if (rd_d) begin
      last_rd = rdata_q;
      if (rd_notes[0][32]) check(rdata_q, rd_notes[0][31:0]);
      void'(rd_notes.pop_front());
    end
    if (lu_ack_q === 1'b1) begin
      if (lu_notes.size() == 0) check(1'b1, 1'b0);
      else check(lu_res_q, lu_notes.pop_front());
    end
    rd_d <= rd;
  end

  // Watchdog sized well above the clear sweep and the register traffic.
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [11:0] offs[9];
    logic [31:0] rnd;
    logic [31:0] up;
    logic [31:0] lo;
    vtar_entry_s e;
    vtar_entry_s z;
    logic [11:0] v;
    offs = '{12'h400, 12'h404, 12'h408, 12'h40C, 12'h40E, 12'h410,
             12'h414, 12'h418, 12'h420};
    void'($urandom(68308));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Every register starts at zero; the unmapped place reads zero.
    foreach (offs[i]) rd_reg(offs[i], 1'b1, 32'h0);
    check(key_q, 56'h0);
    // Clear the whole table, then an unused index forwards by the map.
    run_action(VTAR_ACT_CLR);
    z = '0;
    rnd = $urandom;
    lookup(rnd[11:0], rnd[18:12], exp_lu(z, rnd[18:12]));
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      e = rnd[28:0];
      e.ovr = i[0];
      e.valid = (i != 3);
      v = rnd[31:20] ^ 12'(i);
      // Reserved bits are written as ones and must read back as zero.
      wr_reg(`VT_OFF_ATTR, attr_w(e) | 32'h70FF8F80);
      wr_reg(`VT_OFF_STRIP, {25'h1FFFFFF, e.strip});
      wr_reg(`VT_OFF_EGRESS, {25'h1FFFFFF, e.egress});
      wr_reg(`VT_OFF_INDEX, {20'hFFFFF, v});
      rd_reg(`VT_OFF_ATTR, 1'b1, attr_w(e));
      rd_reg(`VT_OFF_INDEX, 1'b1, {20'h0, v});
      run_action(VTAR_ACT_WR);
      rnd = $urandom;
      lookup(v, rnd[6:0], exp_lu(e, rnd[6:0]));
      // Wipe the staging, then read the entry back into it.
      wr_reg(`VT_OFF_ATTR, 32'h0);
      wr_reg(`VT_OFF_STRIP, 32'h0);
      wr_reg(`VT_OFF_EGRESS, 32'h0);
      run_action(VTAR_ACT_RD);
      rd_reg(`VT_OFF_ATTR, 1'b1, attr_w(e));
      rd_reg(`VT_OFF_STRIP, 1'b1, {25'h0, e.strip});
      rd_reg(`VT_OFF_EGRESS, 1'b1, {25'h0, e.egress});
    end
    // The no-operation code finishes and leaves the table alone.
    run_action(VTAR_ACT_NOP);
    rnd = $urandom;
    lookup(v, rnd[6:0], exp_lu(e, rnd[6:0]));
    // Lookup index registers feed the hash key.
    up = $urandom;
    lo = $urandom;
    wr_reg(`VT_OFF_LU_LOWER, lo);
    wr_reg(`VT_OFF_LU_CTRL, 32'h4);
    // The upper write is followed, after one idle cycle, by its read-back.
    wr_reg(`VT_OFF_LU_UPPER, up);
    rd_reg(`VT_OFF_LU_UPPER, 1'b1, up & 32'h007FFFFF);
    rd_reg(`VT_OFF_LU_LOWER, 1'b1, lo);
    rd_reg(`VT_OFF_LU_CTRL, 1'b1, 32'h00000004);
    repeat (3) @(posedge clk_sys);
    check(key_q, {1'b1, up[22:16], up[15:0], lo});
    check(rd_notes.size() + lu_notes.size(), 0);
    complete_run();
  end
endmodule : tb
